// file: dv/pgit_mcu_model.sv
// Far side model: regulator enable in, microcontroller acknowledge out.
// Assumes the bench holds ack_en low when no acknowledge is wanted.
module pgit_mcu_model (
  // Clock
  input  wire logic        clock,
  // Enable from the timer
  input  wire logic        power_enable_out,
  // Controls
  input  wire logic        ack_en,
  input  wire logic [15:0] ack_delay,
  // Acknowledge
  output logic             ack_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic en_q;
  int   cnt;

  // ****
  // Cycles since the enable rose
  // ****
  always_ff @(posedge clock) begin
    en_q <= power_enable_out;
    cnt  <= (power_enable_out && !en_q) ? 0 : cnt + 1;
  end

  // Six-cycle pulse, then a late second one that must be ignored
  assign ack_in = ack_en && ((cnt >= ack_delay && cnt < ack_delay + 6) ||
    (cnt >= ack_delay + 20 && cnt < ack_delay + 26));
endmodule

// file: dv/pgit_timer_chk.sv
// Checker for the timer, bound to its ports.
// Assumes the pin and mode inputs are driven on the clock edge.
module pgit_timer_chk
  import pgit_pkg::*;
#(
  parameter int CYC_PER_MS = 50000,
  parameter int INTERVAL_W = 23
) (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  rst,
  // Pins
  input wire logic                  mode_select,
  input wire logic                  ack_in,
  input wire logic                  interval_set_manual_on_pin,
  input wire logic [INTERVAL_W-1:0] interval_resistor_ms,
  // Outputs
  input wire logic                  power_enable_out,
  input wire logic                  measure_active,
  input wire logic [INTERVAL_W-1:0] interval_period
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  int   lo_cnt, hi_cnt, per_cnt, quiet_cnt, pin_cnt;
  logic seen, press_lo;

  // ****
  // Run lengths
  // ****
  always_ff @(posedge clock) begin
    lo_cnt    <= power_enable_out ? 0 : lo_cnt + 1;
    hi_cnt    <= power_enable_out ? hi_cnt + 1 : 0;
    quiet_cnt <= interval_set_manual_on_pin ? 0 : quiet_cnt + 1;
    pin_cnt   <= interval_set_manual_on_pin ? pin_cnt + 1 : 0;
  end

  // Time since last rise; whether the output was low when the pin was pressed
  always_ff @(posedge clock) begin
    if (rst) begin
      seen    <= 1'b0;
      per_cnt <= 0;
    end else if (power_enable_out && lo_cnt > 0) begin
      seen    <= 1'b1;
      per_cnt <= 1;
    end else begin
      per_cnt <= per_cnt + 1;
    end
    if (interval_set_manual_on_pin && pin_cnt == 0) begin
      press_lo <= !power_enable_out;
    end
  end

  // ****
  // Properties
  // ****
  meas_once_a: assert property (!measure_active |=> !measure_active)
    else $error("read phase ran again");
  meas_quiet_a: assert property (measure_active |-> !power_enable_out)
    else $error("enable high during read");
  start_high_a: assert property ($fell(measure_active) |-> power_enable_out)
    else $error("enable not high after read");
  ack_drop_a: assert property ($rose(ack_in) && power_enable_out &&
    quiet_cnt > 25 * CYC_PER_MS |-> ##[2:4] !power_enable_out)
    else $error("acknowledge did not end pulse");
  tail_len_a: assert property (power_enable_out && lo_cnt > 0 &&
    quiet_cnt > lo_cnt |-> lo_cnt >= 49 * CYC_PER_MS)
    else $error("low tail too short");
  period_a: assert property (power_enable_out && lo_cnt > 0 && seen &&
    quiet_cnt > per_cnt |-> mode_select &&
    per_cnt >= (interval_period - 1) * CYC_PER_MS &&
    per_cnt <= (interval_period + 1) * CYC_PER_MS)
    else $error("pulse period wrong");
  hi_len_a: assert property (power_enable_out &&
    quiet_cnt > hi_cnt + 25 * CYC_PER_MS |->
    hi_cnt <= (interval_period - 49) * CYC_PER_MS)
    else $error("pulse too long");
  manual_hold_a: assert property (pin_cnt == 24 * CYC_PER_MS &&
    press_lo && !measure_active |-> power_enable_out ##1 power_enable_out)
    else $error("manual request not honoured");
  abort_read_a: assert property (measure_active &&
    interval_set_manual_on_pin |=> measure_active)
    else $error("read not held by pin");
  interval_fixed_a: assert property (!measure_active |=>
    $stable(interval_period))
    else $error("interval changed after read");
endmodule

bind pgit_timer pgit_timer_chk #(
  .CYC_PER_MS(CYC_PER_MS),
  .INTERVAL_W(INTERVAL_W)
) u_pgit_timer_chk (
  .clock(clock),
  .rst(rst),
  .mode_select(mode_select),
  .ack_in(ack_in),
  .interval_set_manual_on_pin(interval_set_manual_on_pin),
  .interval_resistor_ms(interval_resistor_ms),
  .power_enable_out(power_enable_out),
  .measure_active(measure_active),
  .interval_period(interval_period)
);

// file: dv/pgit_timer_test.sv
// Self-checking bench for the timer with a shortened millisecond.
// Assumes a ms of 10 clocks and an interval input of 150 ms.
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: %h %h", $time, (a), (e)); end end
module pgit_timer_test
  import pgit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rst, mode_select, ack_in, man_pin, ack_en;
  logic        pen, meas;
  logic [22:0] ivl, ivl_in;
  int          fail_count, comparisons, n;

  pgit_timer #(.CYC_PER_MS(10)) u_pgit_timer (.clock(clock), .rst(rst),
    .mode_select(mode_select), .ack_in(ack_in),
    .interval_set_manual_on_pin(man_pin), .interval_resistor_ms(ivl_in),
    .power_enable_out(pen), .measure_active(meas), .interval_period(ivl));
  pgit_mcu_model u_pgit_mcu_model (.clock(clock), .power_enable_out(pen),
    .ack_en(ack_en), .ack_delay(16'h00c8), .ack_in(ack_in));

  // ****
  // Helpers
  // ****
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task do_reset(input logic m);
    mode_select <= m;
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
  endtask
  task wait_out(input logic v);
    n = 0;
    while (pen !== v) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 20000) begin
        fail_count++;
        final_report();
      end
    end
  endtask
  task hold_pin(input int c);
    @(posedge clock);
    man_pin <= 1'b1;
    repeat (c) @(posedge clock);
    man_pin <= 1'b0;
    #1;
  endtask

  // ****
  // Scenarios
  // ****
  task t_timer;
    do_reset(1'b1);
    wait_out(1'b1);
    `CHK(n >= 1000 && n <= 1200, 1'b1)
    `CHK(meas, 1'b0)
    `CHK(ivl, 23'h96)
    wait_out(1'b0);
    `CHK(n >= 990 && n <= 1010, 1'b1)
    wait_out(1'b1);
    `CHK(n >= 490 && n <= 510, 1'b1)
    $display("timer test done");
  endtask
  task t_ack;
    @(posedge clock);
    ack_en <= 1'b1;
    wait_out(1'b0);
    `CHK(n >= 195 && n <= 210, 1'b1)
    wait_out(1'b1);
    `CHK(n >= 1280 && n <= 1310, 1'b1)
    @(posedge clock);
    ack_en <= 1'b0;
    $display("ack test done");
  endtask
  task t_oneshot;
    do_reset(1'b0);
    wait_out(1'b1);
    wait_out(1'b0);
    `CHK(n >= 990 && n <= 1010, 1'b1)
    repeat (3000) @(posedge clock);
    `CHK(pen, 1'b0)
    hold_pin(100);
    repeat (500) @(posedge clock);
    `CHK(pen, 1'b0)
    hold_pin(240);
    `CHK(pen, 1'b1)
    wait_out(1'b0);
    `CHK(n >= 1180 && n <= 1230, 1'b1)
    repeat (3000) @(posedge clock);
    `CHK(pen, 1'b0)
    $display("one-shot test done");
  endtask
  task t_abort;
    do_reset(1'b1);
    repeat (300) @(posedge clock);
    hold_pin(300);
    `CHK(meas, 1'b1)
    wait_out(1'b1);
    `CHK(n >= 1190 && n <= 1230, 1'b1)
    $display("abort test done");
  endtask
  task t_clamp;
    ivl_in <= 23'h000010;
    do_reset(1'b1);
    wait_out(1'b1);
    `CHK(ivl, 23'h000064)
    wait_out(1'b0);
    `CHK(n >= 490 && n <= 510, 1'b1)
    $display("clamp test done");
  endtask

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    rst = 1'b1;
    mode_select = 1'b1;
    man_pin = 1'b0;
    ack_en = 1'b0;
    ivl_in = 23'h000096;
    fail_count = 0;
    comparisons = 0;
    t_timer();
    t_ack();
    t_oneshot();
    t_abort();
    t_clamp();
    final_report();
  end
endmodule

// file: verilog/pgit_map.svh
// Timing constants of the power gating interval timer.
// Assumes the core clock figure below matches the clock pin.
`ifndef PGIT_MAP_SVH
`define PGIT_MAP_SVH

// ****************************************************
// Clock
// ****************************************************
`define PGIT_CLOCK_HZ        50000000
`define PGIT_MS_PER_S        1000
`define PGIT_CYC_PER_MS      (`PGIT_CLOCK_HZ / `PGIT_MS_PER_S)

// ****************************************************
// Times in milliseconds
// ****************************************************
`define PGIT_READ_MS         100
`define PGIT_READ_MAX_MS     120
`define PGIT_OFF_TAIL_MS     50
`define PGIT_DEBOUNCE_MS     20
`define PGIT_MANUAL_MIN_MS   20
`define PGIT_OBSERVE_MS      30
`define PGIT_RAISE_MAX_MS    10
`define PGIT_MIN_INTERVAL_MS 100
`define PGIT_MAX_INTERVAL_MS 7200000

// ****************************************************
// Widths
// ****************************************************
`define PGIT_MS_W            23
`define PGIT_WIN_W           5

`endif

// file: verilog/pgit_pkg.sv
// Types shared by the power gating interval timer.
// Assumes nothing beyond the timing header.
package pgit_pkg;

  // ****************************************************
  // Sequencer states
  // ****************************************************
  typedef enum logic [2:0] {
    ST_MEASURE,
    ST_MEAS_HOLD,
    ST_RUN_ON,
    ST_RUN_OFF,
    ST_IDLE,
    ST_MANUAL
  } pgit_state_t;

endpackage

// file: verilog/pgit_timer.sv
// Power gating interval timer: drives a regulator enable periodically
// or once, shortened by an acknowledge edge, with a manual power-on pin.
// Assumes all inputs except clock and rst are asynchronous pins and that
// the interval code from the measurement chain is steady during a read.
//
// How it works
// - Timer mode repeats pulse every interval
// - Pulse lasts interval minus 50 ms
// - Output low during final 50 ms
// - Output high when interval starts after read
// - Only acknowledge rising edge counts
// - Only first acknowledge per interval acts
// - Accepted acknowledge drops output until interval end
// - Single interval read after reset first
// - Interval read takes 100 ms, below 120
// - Mode chosen by fixed select level
// - One-shot mode gives one pulse
// - Manual request in one-shot gives one pulse
// - Interval selectable 100 ms to 7200 s
// - Pin high after start means manual on
// - Manual during read aborts, restarts read
// - Manual valid if high 20 of 30 ms
// - Manual ignored while output high
// - Manual pin debounced 20 ms both edges
// - Output rises within 10 ms of manual
// - Manual clears counters until pin low
// - Held pin keeps output high, ignores acknowledge
// - Acknowledge discarded while pin high
`include "pgit_map.svh"
module pgit_timer
  import pgit_pkg::*;
#(
  parameter int CYC_PER_MS = `PGIT_CYC_PER_MS,
  parameter int INTERVAL_W = `PGIT_MS_W
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Mode select pin, high for timer mode
  input  wire logic                  mode_select,
  // Acknowledge from the microcontroller
  input  wire logic                  ack_in,
  // Interval-set pin, digital view
  input  wire logic                  interval_set_manual_on_pin,
  // Interval in ms from the resistor measurement chain
  input  wire logic [INTERVAL_W-1:0] interval_resistor_ms,
  // Regulator enable
  output logic                       power_enable_out,
  // Measurement chain connected to the pin
  output logic                       measure_active,
  // Interval in use
  output logic [INTERVAL_W-1:0]      interval_period
);

  // ****************************************************
  // Local constants
  // ****************************************************
  localparam int PRE_W = $clog2(CYC_PER_MS);

  localparam logic [PRE_W-1:0] PRE_LAST =
    PRE_W'(CYC_PER_MS - 1);

  localparam logic [INTERVAL_W-1:0] READ_LAST =
    INTERVAL_W'(`PGIT_READ_MS - 1);
  localparam logic [INTERVAL_W-1:0] TAIL =
    INTERVAL_W'(`PGIT_OFF_TAIL_MS);
  localparam logic [INTERVAL_W-1:0] IVL_MIN =
    INTERVAL_W'(`PGIT_MIN_INTERVAL_MS);
  localparam logic [INTERVAL_W-1:0] IVL_MAX =
    INTERVAL_W'(`PGIT_MAX_INTERVAL_MS);

  localparam logic [`PGIT_WIN_W-1:0] DB_LAST =
    `PGIT_WIN_W'(`PGIT_DEBOUNCE_MS - 1);
  localparam logic [`PGIT_WIN_W-1:0] MAN_LAST =
    `PGIT_WIN_W'(`PGIT_MANUAL_MIN_MS - 1);
  localparam logic [`PGIT_WIN_W-1:0] WIN_LAST =
    `PGIT_WIN_W'(`PGIT_OBSERVE_MS - 1);

  // ****************************************************
  // Functions
  // ****************************************************
  // Keeps the programmed interval inside the legal range
  function automatic logic [INTERVAL_W-1:0] clamp_interval(
    input logic [INTERVAL_W-1:0] ms
  );
    if (ms < IVL_MIN) begin
      return IVL_MIN;
    end
    if (ms > IVL_MAX) begin
      return IVL_MAX;
    end
    return ms;
  endfunction

  // True on the millisecond tick that ends count value target
  function automatic logic ms_hit(
    input logic                  tk,
    input logic [INTERVAL_W-1:0] cnt,
    input logic [INTERVAL_W-1:0] target
  );
    return tk && (cnt == target);
  endfunction

  // ****************************************************
  // Declarations
  // ****************************************************
  logic                  mode_s1;
  logic                  mode_s2;
  logic                  ack_s1;
  logic                  ack_s2;
  logic                  ack_prev;
  logic                  pin_s1;
  logic                  pin_s2;
  logic [INTERVAL_W-1:0] ivl_s1;
  logic [INTERVAL_W-1:0] ivl_s2;

  logic [PRE_W-1:0]      pre_cnt;
  logic                  tick;

  logic                  man_level;
  logic                  man_rise;
  logic [`PGIT_WIN_W-1:0] fall_cnt;
  logic [`PGIT_WIN_W-1:0] win_cnt;
  logic [`PGIT_WIN_W-1:0] high_cnt;
  logic                  win_open;

  pgit_state_t           state;
  pgit_state_t           next_state;
  logic                  next_enable;
  logic                  clear_cnt;
  logic                  take_interval;
  logic                  mode_timer;
  logic [INTERVAL_W-1:0] ms_cnt;
  logic                  ack_rise;

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
      ack_s1  <= 1'b0;
      ack_s2  <= 1'b0;
      pin_s1  <= 1'b0;
      pin_s2  <= 1'b0;
      ivl_s1  <= '0;
      ivl_s2  <= '0;
    end else begin
      mode_s1 <= mode_select;
      mode_s2 <= mode_s1;
      ack_s1  <= ack_in;
      ack_s2  <= ack_s1;
      pin_s1  <= interval_set_manual_on_pin;
      pin_s2  <= pin_s1;
      ivl_s1  <= interval_resistor_ms;
      ivl_s2  <= ivl_s1;
    end
  end

  // A 100 ns pulse spans five clocks, enough for the synchroniser
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_prev <= 1'b0;
    end else begin
      ack_prev <= ack_s2;
    end
  end

  assign ack_rise = ack_s2 && !ack_prev;

  // ****************************************************
  // Millisecond prescaler
  // ****************************************************
  always_ff @(posedge clock) begin
    if (rst || pre_cnt == PRE_LAST) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  assign tick = (pre_cnt == PRE_LAST);

  // ****************************************************
  // Manual power-on qualifier
  // ****************************************************
  // Rising side: high for 20 ms inside a 30 ms window
  always_ff @(posedge clock) begin
    if (rst || man_level) begin
      win_open <= 1'b0;
      win_cnt  <= '0;
      high_cnt <= '0;
    end else if (!win_open) begin
      if (pin_s2) begin
        win_open <= 1'b1;
      end
    end else if (tick) begin
      if (win_cnt == WIN_LAST) begin
        win_open <= 1'b0;
        win_cnt  <= '0;
        high_cnt <= '0;
      end else begin
        win_cnt <= win_cnt + 1'b1;
        if (pin_s2) begin
          high_cnt <= high_cnt + 1'b1;
        end
      end
    end
  end

  // Falling side: low for a full debounce time
  always_ff @(posedge clock) begin
    if (rst || !man_level || pin_s2) begin
      fall_cnt <= '0;
    end else if (tick) begin
      fall_cnt <= fall_cnt + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      man_level <= 1'b0;
      man_rise  <= 1'b0;
    end else begin
      man_rise <= 1'b0;
      if (!man_level && win_open && tick && pin_s2
          && high_cnt == MAN_LAST) begin
        man_level <= 1'b1;
        man_rise  <= 1'b1;
      end else if (man_level && tick && !pin_s2
                   && fall_cnt == DB_LAST) begin
        man_level <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Interval and mode capture
  // ****************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      interval_period <= IVL_MIN;
      mode_timer      <= 1'b0;
    end else if (take_interval) begin
      interval_period <= clamp_interval(ivl_s2);
      mode_timer      <= mode_s2;
    end
  end

  // ****************************************************
  // Interval counter
  // ****************************************************
  always_ff @(posedge clock) begin
    if (rst || clear_cnt) begin
      ms_cnt <= '0;
    end else if (tick) begin
      ms_cnt <= ms_cnt + 1'b1;
    end
  end

  // ****************************************************
  // Sequencer
  // ****************************************************
  always_comb begin
    next_state    = state;
    next_enable   = power_enable_out;
    clear_cnt     = 1'b0;
    take_interval = 1'b0;
    case (state)
      ST_MEASURE: begin
        if (man_level || pin_s2 && win_open) begin
          next_state = ST_MEAS_HOLD;
          clear_cnt  = 1'b1;
        end else if (ms_hit(tick, ms_cnt, READ_LAST)) begin
          next_state    = ST_RUN_ON;
          next_enable   = 1'b1;
          clear_cnt     = 1'b1;
          take_interval = 1'b1;
        end
      end
      ST_MEAS_HOLD: begin
        clear_cnt = 1'b1;
        if (!man_level && !win_open) begin
          next_state = ST_MEASURE;
        end
      end
      ST_RUN_ON: begin
        if (ack_rise && !man_level) begin
          next_state  = ST_RUN_OFF;
          next_enable = 1'b0;
        end else if (ms_hit(tick, ms_cnt,
                            interval_period - TAIL - 1'b1)) begin
          next_state  = ST_RUN_OFF;
          next_enable = 1'b0;
        end
      end
      ST_RUN_OFF: begin
        // Later acknowledge edges fall here and are dropped
        if (man_rise) begin
          next_state  = ST_MANUAL;
          next_enable = 1'b1;
          clear_cnt   = 1'b1;
        end else if (ms_hit(tick, ms_cnt,
                            interval_period - 1'b1)) begin
          clear_cnt = 1'b1;
          if (mode_timer) begin
            next_state  = ST_RUN_ON;
            next_enable = 1'b1;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        clear_cnt = 1'b1;
        if (man_rise) begin
          next_state  = ST_MANUAL;
          next_enable = 1'b1;
        end
      end
      ST_MANUAL: begin
        clear_cnt = 1'b1;
        if (!man_level) begin
          next_state = ST_RUN_ON;
        end
      end
      default: begin
        next_state  = ST_MEASURE;
        next_enable = 1'b0;
        clear_cnt   = 1'b1;
      end
    endcase
  end

  // A manual rise while the output is high never leaves ST_RUN_ON
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_MEASURE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      power_enable_out <= 1'b0;
    end else begin
      power_enable_out <= next_enable;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      measure_active <= 1'b1;
    end else begin
      measure_active <= (next_state inside {ST_MEASURE, ST_MEAS_HOLD});
    end
  end

endmodule
